/* rtl/fts_pkg.sv */
// Purpose: shared constants and types for the flash timeout supervisor
// Assumes: 20 MHz clock, times kept in microseconds
// Notes:   cycle counts derive from the times and the clock rate
package fts_pkg;
    localparam int CLK_MHZ          = 20;
    localparam int ERASE_TYP_US     = 100000;
    localparam int ERASE_MAX_US     = 240000;
    localparam int PROG_TYP_US      = 2000;
    localparam int PROG_MAX_US      = 12000;
    localparam int ERASE_TMO_US     = 793000;
    localparam int PROG_TMO_US      = 39600;
    localparam int ERASE_MAX_CYC    = ERASE_MAX_US * CLK_MHZ;
    localparam int PROG_MAX_CYC     = PROG_MAX_US * CLK_MHZ;
    localparam int ERASE_TMO_CYC    = ERASE_TMO_US * CLK_MHZ;
    localparam int PROG_TMO_CYC     = PROG_TMO_US * CLK_MHZ;
    localparam int CNT_W            = 24;

    localparam logic [15:0] ENTRY_READ_MODE  = 16'haa00;
    localparam logic [15:0] ENTRY_RESET_VAL  = 16'h0000;
    localparam logic [1:0]  MODE_USER_BOOT   = 2'h2;
    localparam logic [1:0]  MODE_RESET_VAL   = 2'h0;

    localparam logic [31:0] UBOOT_RESET_VEC  = 32'hff7ffffc;
    localparam logic [31:0] NORM_RESET_VEC   = 32'hfffffffc;
    localparam logic [31:0] FIXED_VEC_LO     = 32'hffffffd0;
    localparam logic [31:0] FIXED_VEC_HI     = 32'hffffffff;
    localparam logic [31:0] LOW_BLK_PE_BASE  = 32'h00fff000;
    localparam logic [31:0] LOW_BLK_RD_BASE  = 32'hfffff000;
    localparam logic [31:0] LOW_BLK_MASK     = 32'hfffff000;
    localparam logic [31:0] ID_CODE_LO       = 32'hffffffa0;
    localparam logic [31:0] ID_CODE_HI       = 32'hffffffaf;

    typedef enum logic [1:0] {
        OP_READ_MODE = 2'h0,
        OP_ERASE     = 2'h1,
        OP_PROGRAM   = 2'h2
    } fts_op_type;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_ISSUE  = 4'b0010,
        ST_WAIT   = 4'b0100,
        ST_REINIT = 4'b1000
    } fts_state_type;

    typedef struct packed {
        fts_op_type  op;
        logic [31:0] addr;
    } fts_req_type;

    typedef struct packed {
        logic        granted;
        logic        fixed_vec;
        logic        id_code;
        logic        lowest_block;
        logic [31:0] flash_addr;
    } fts_map_type;
endpackage : fts_pkg

/* rtl/fts_addr_map.sv */
// Purpose: decode of host flash addresses against the boot map
// Assumes: one access request per cycle, same clock as the supervisor
// Notes:   result is registered, one cycle after the request
`timescale 1ns/1ps
module fts_addr_map
    import fts_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        rd_i,
    input  wire logic        pe_i,
    input  wire logic        id_protect_i,
    output fts_map_type      map_o
);
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    logic in_low_rd;
    logic in_low_pe;
    assign in_low_rd = (addr_i & LOW_BLK_MASK) == LOW_BLK_RD_BASE;
    assign in_low_pe = (addr_i & LOW_BLK_MASK) == LOW_BLK_PE_BASE;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            map_o <= '0;
        end else begin
            map_o.granted      <= (rd_i | pe_i) & ~id_protect_i;
            map_o.fixed_vec    <= rd_i & in_range(addr_i, FIXED_VEC_LO, FIXED_VEC_HI);
            map_o.id_code      <= rd_i & in_range(addr_i, ID_CODE_LO, ID_CODE_HI);
            map_o.lowest_block <= (rd_i & in_low_rd) | (pe_i & in_low_pe);
            // same block seen through two windows; fold read view onto program view
            if (rd_i & in_low_rd) begin
                map_o.flash_addr <= LOW_BLK_PE_BASE | (addr_i & ~LOW_BLK_MASK);
            end else begin
                map_o.flash_addr <= addr_i;
            end
        end
    end
endmodule : fts_addr_map

/* rtl/fts_supervisor.sv */
// Purpose: issues flash operations and guards the ready flag with timeouts
// Assumes: flash control unit runs on mclk_i and drops ready after a command
// Notes:   long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module fts_supervisor
    import fts_pkg::*;
#(
    parameter int ERASE_TMO = ERASE_TMO_CYC,
    parameter int PROG_TMO  = PROG_TMO_CYC,
    parameter int ERASE_MAX = ERASE_MAX_CYC,
    parameter int PROG_MAX  = PROG_MAX_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        req_valid_i,
    input  fts_req_type      req_i,
    output logic             req_ready_o,
    output logic             req_refused_o,
    input  wire logic        flash_ready_flag_i,
    output logic             entry_wr_o,
    output logic [15:0]      flash_entry_register_o,
    output logic             erase_cmd_o,
    output logic             prog_cmd_o,
    output logic [31:0]      cmd_addr_o,
    output logic             reinit_o,
    output logic             done_o,
    output logic             timeout_err_o,
    output logic             slow_o,
    output logic             rewrite_needed_o,
    input  wire logic        rewrite_ack_i,
    input  wire logic        id_protect_i,
    input  wire logic        mode_select_pin_high_i,
    input  wire logic        mode_select_pin_low_i,
    output logic [31:0]      reset_vector_o,
    output logic             user_boot_o,
    input  wire logic [31:0] host_addr_i,
    input  wire logic        host_rd_i,
    input  wire logic        host_pe_i,
    output fts_map_type      host_map_o
);
    localparam logic [CNT_W-1:0] ERASE_LIM = CNT_W'(ERASE_TMO);
    localparam logic [CNT_W-1:0] PROG_LIM  = CNT_W'(PROG_TMO);
    localparam logic [CNT_W-1:0] ERASE_SPC = CNT_W'(ERASE_MAX);
    localparam logic [CNT_W-1:0] PROG_SPC  = CNT_W'(PROG_MAX);

    fts_state_type    state_q;
    fts_op_type       op_q;
    logic [CNT_W-1:0] cnt_q;
    logic [1:0]       mode_meta_q;
    logic [1:0]       mode_sync_q;
    logic             boot_caught_q;
    logic             low_blk_q;
    logic             timed_out;
    logic             finished;
    logic             start;
    logic             erase_low_done;

    // long erase limit also covers the read-mode wait
    function automatic logic [CNT_W-1:0] tmo_for(input fts_op_type op);
        tmo_for = (op == OP_PROGRAM) ? PROG_LIM : ERASE_LIM;
    endfunction : tmo_for

    assign req_ready_o    = state_q == ST_IDLE;
    assign start          = req_ready_o & req_valid_i & ~id_protect_i;
    assign finished       = (state_q == ST_WAIT) & flash_ready_flag_i & (cnt_q != '0);
    assign timed_out      = (state_q == ST_WAIT) & ~finished
                            & (cnt_q >= tmo_for(op_q));
    assign erase_low_done = finished & (op_q == OP_ERASE) & low_blk_q;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (finished) begin
                        state_q <= ST_IDLE;
                    end else if (timed_out) begin
                        state_q <= ST_REINIT;
                    end
                end
                ST_REINIT: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            op_q       <= OP_READ_MODE;
            cmd_addr_o <= '0;
            low_blk_q  <= 1'b0;
        end else if (start) begin
            op_q       <= req_i.op;
            cmd_addr_o <= req_i.addr;
            low_blk_q  <= (req_i.addr & LOW_BLK_MASK) == LOW_BLK_PE_BASE;
        end
    end

    // counter saturates at the limit; it only runs while waiting
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cnt_q <= '0;
        end else if (state_q == ST_WAIT) begin
            if (cnt_q < tmo_for(op_q)) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end else begin
            cnt_q <= '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            entry_wr_o             <= 1'b0;
            flash_entry_register_o <= ENTRY_RESET_VAL;
            erase_cmd_o            <= 1'b0;
            prog_cmd_o             <= 1'b0;
            reinit_o               <= 1'b0;
            done_o                 <= 1'b0;
            req_refused_o          <= 1'b0;
        end else begin
            entry_wr_o    <= start & (req_i.op == OP_READ_MODE);
            erase_cmd_o   <= start & (req_i.op == OP_ERASE);
            prog_cmd_o    <= start & (req_i.op == OP_PROGRAM);
            reinit_o      <= timed_out;
            done_o        <= finished;
            req_refused_o <= req_ready_o & req_valid_i & id_protect_i;
            if (start & (req_i.op == OP_READ_MODE)) begin
                flash_entry_register_o <= ENTRY_READ_MODE;
            end
        end
    end

    // error stands until the next accepted operation
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            timeout_err_o <= 1'b0;
        end else if (timed_out) begin
            timeout_err_o <= 1'b1;
        end else if (start) begin
            timeout_err_o <= 1'b0;
        end
    end

    // slow: ready came after the device maximum but inside the margin
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            slow_o <= 1'b0;
        end else if (finished) begin
            if (op_q == OP_PROGRAM) begin
                slow_o <= cnt_q > PROG_SPC;
            end else begin
                slow_o <= cnt_q > ERASE_SPC;
            end
        end else if (start) begin
            slow_o <= 1'b0;
        end
    end

    // set wins over the acknowledge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rewrite_needed_o <= 1'b0;
        end else if (erase_low_done) begin
            rewrite_needed_o <= 1'b1;
        end else if (rewrite_ack_i) begin
            rewrite_needed_o <= 1'b0;
        end
    end

    // mode pins are asynchronous; only the second stage is read
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mode_meta_q <= MODE_RESET_VAL;
            mode_sync_q <= MODE_RESET_VAL;
        end else begin
            mode_meta_q <= {mode_select_pin_high_i, mode_select_pin_low_i};
            mode_sync_q <= mode_meta_q;
        end
    end

    // strap caught once after release, third edge when the sync has settled
    logic [1:0] boot_wait_q;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            boot_wait_q    <= 2'h0;
            boot_caught_q  <= 1'b0;
            user_boot_o    <= 1'b0;
            reset_vector_o <= NORM_RESET_VEC;
        end else if (!boot_caught_q) begin
            if (boot_wait_q == 2'h2) begin
                boot_caught_q <= 1'b1;
                user_boot_o   <= mode_sync_q == MODE_USER_BOOT;
                if (mode_sync_q == MODE_USER_BOOT) begin
                    reset_vector_o <= UBOOT_RESET_VEC;
                end else begin
                    reset_vector_o <= NORM_RESET_VEC;
                end
            end else begin
                boot_wait_q <= boot_wait_q + 2'h1;
            end
        end
    end

    fts_addr_map u_map (
        .mclk_i       (mclk_i),
        .srst_i       (srst_i),
        .addr_i       (host_addr_i),
        .rd_i         (host_rd_i),
        .pe_i         (host_pe_i),
        .id_protect_i (id_protect_i),
        .map_o        (host_map_o)
    );
endmodule : fts_supervisor

/* verification/fts_flash_model.sv */
// Purpose: behavioural flash control unit answering on the ready flag
// Assumes: any command or entry write starts one busy period
// Notes:   busy length comes from the bench, scaled down from real times
`timescale 1ns/1ps
module fts_flash_model (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        start_i,
    input  wire logic        reinit_i,
    input  wire logic [31:0] busy_cyc_i,
    output logic             ready_o
);
    int cnt_q;

    // ready drops at once, so a slow supervisor cannot see a stale high
    always_ff @(posedge mclk_i) begin
        if (srst_i || reinit_i) begin
            ready_o <= 1'b1;
            cnt_q   <= 0;
        end else if (start_i) begin
            ready_o <= 1'b0;
            cnt_q   <= int'(busy_cyc_i);
        end else if (cnt_q > 1) begin
            cnt_q   <= cnt_q - 1;
        end else begin
            ready_o <= 1'b1;
        end
    end
endmodule : fts_flash_model

/* verification/fts_supervisor_monitor.sv */
// Purpose: concurrent checks on the flash timeout supervisor ports
// Assumes: bound to fts_supervisor, counts handed down from it
// Notes:   helper counter times each op from its take edge
`timescale 1ns/1ps
module fts_supervisor_monitor
    import fts_pkg::*;
#(
    parameter int ERASE_TMO = ERASE_TMO_CYC,
    parameter int PROG_TMO  = PROG_TMO_CYC
) (
    input wire logic        mclk_i,
    input wire logic        srst_i,
    input wire logic        req_valid_i,
    input fts_req_type      req_i,
    input wire logic        req_ready_o,
    input wire logic        req_refused_o,
    input wire logic        id_protect_i,
    input wire logic        entry_wr_o,
    input wire logic [15:0] flash_entry_register_o,
    input wire logic        erase_cmd_o,
    input wire logic        prog_cmd_o,
    input wire logic        done_o,
    input wire logic        reinit_o,
    input wire logic        timeout_err_o,
    input wire logic        rewrite_needed_o,
    input wire logic        rewrite_ack_i,
    input wire logic        user_boot_o,
    input wire logic [31:0] reset_vector_o,
    input wire logic        mode_select_pin_high_i,
    input wire logic        mode_select_pin_low_i,
    input wire logic        host_rd_i,
    input wire logic        host_pe_i,
    input wire logic [31:0] host_addr_i,
    input fts_map_type      host_map_o
);
    localparam int E_END = ERASE_TMO + 3;
    localparam int P_END = PROG_TMO + 3;
    logic        take;
    int          cyc_q;
    fts_op_type  op_q;
    logic [31:0] addr_q;

    assign take = req_valid_i && req_ready_o && !id_protect_i;
    // counter rather than delay ranges: real limits run to millions of cycles
    always_ff @(posedge mclk_i) begin
        cyc_q  <= take ? 1 : cyc_q + 1;
        op_q   <= take ? req_i.op : op_q;
        addr_q <= take ? req_i.addr : addr_q;
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    sequence s_take_read;  take && req_i.op == OP_READ_MODE; endsequence
    sequence s_take_erase; take && req_i.op == OP_ERASE;     endsequence
    sequence s_take_prog;  take && req_i.op == OP_PROGRAM;   endsequence

    AST_ENTRY_VALUE: assert property (entry_wr_o |->
        flash_entry_register_o == ENTRY_READ_MODE)
        else $error("entry write without read mode code");
    AST_READ_ISSUE: assert property (s_take_read |=>
        entry_wr_o && !req_ready_o ##1 !entry_wr_o)
        else $error("read mode request not issued");
    AST_ERASE_ISSUE: assert property (s_take_erase |=> erase_cmd_o ##1 (!done_o)[*2])
        else $error("erase not issued or ended too soon");
    AST_PROG_ISSUE: assert property (s_take_prog |=> prog_cmd_o && !erase_cmd_o)
        else $error("program not issued");
    AST_REFUSE: assert property (req_valid_i && req_ready_o && id_protect_i
        |=> req_refused_o && req_ready_o && !erase_cmd_o && !prog_cmd_o)
        else $error("protected request not refused");
    AST_ERASE_LIMIT: assert property (reinit_o && op_q != OP_PROGRAM |-> cyc_q == E_END)
        else $error("erase timeout at wrong cycle");
    AST_PROG_LIMIT: assert property (reinit_o && op_q == OP_PROGRAM |-> cyc_q == P_END)
        else $error("program timeout at wrong cycle");
    AST_PROG_BOUND: assert property (!req_ready_o && op_q == OP_PROGRAM |-> cyc_q <= P_END)
        else $error("program wait overran its bound");
    AST_REINIT_IDLE: assert property (reinit_o |=>
        req_ready_o && timeout_err_o && !reinit_o)
        else $error("timeout recovery wrong");
    AST_REWRITE: assert property (done_o && op_q == OP_ERASE && !rewrite_ack_i
        && (addr_q & LOW_BLK_MASK) == LOW_BLK_PE_BASE |=> rewrite_needed_o)
        else $error("lowest block erase did not demand rewrite");
    AST_HOST_GRANT: assert property (!$past(srst_i) |-> host_map_o.granted
        == $past((host_rd_i || host_pe_i) && !id_protect_i))
        else $error("host grant wrong");
    AST_FIXED_VEC: assert property (!$past(srst_i) |-> host_map_o.fixed_vec
        == $past(host_rd_i && host_addr_i >= FIXED_VEC_LO))
        else $error("fixed vector decode wrong");
    AST_LOW_FOLD: assert property ($past(host_rd_i && (host_addr_i & LOW_BLK_MASK)
        == LOW_BLK_RD_BASE) && !$past(srst_i) |-> host_map_o.flash_addr
        == (LOW_BLK_PE_BASE | ($past(host_addr_i) & ~LOW_BLK_MASK)))
        else $error("lowest block address not folded");
    AST_BOOT_VEC: assert property (reset_vector_o
        == (user_boot_o ? UBOOT_RESET_VEC : NORM_RESET_VEC))
        else $error("reset vector does not match boot mode");
    // pins reach the latch through two stages, so look three edges back
    AST_BOOT_PINS: assert property ($changed(reset_vector_o) |-> user_boot_o
        && $past(mode_select_pin_high_i && !mode_select_pin_low_i, 3))
        else $error("user boot vector taken without user boot pins");
endmodule : fts_supervisor_monitor

bind fts_supervisor fts_supervisor_monitor #(.ERASE_TMO(ERASE_TMO), .PROG_TMO(PROG_TMO))
    mon_u (.*);

/* verification/tb_top.sv */
// Purpose: self-checking bench for the flash timeout supervisor
// Assumes: shortened counts, flash model on the far side
// Notes:   table rows for plain ops, hand tests after
`timescale 1ns/1ps
module tb_top;
    import fts_pkg::*;
    typedef struct {fts_op_type op; logic [31:0] addr; int dly; logic tmo;
                    logic slow;} fts_row_type;
    logic        mclk_i = 0, srst_i = 1, req_valid_i = 0, flash_ready_flag_i;
    logic        rewrite_ack_i = 0, id_protect_i = 0, host_rd_i = 0, host_pe_i = 0;
    logic        mode_select_pin_high_i = 1, mode_select_pin_low_i = 0, fin;
    logic [31:0] host_addr_i = '0, cmd_addr_o, reset_vector_o;
    logic [15:0] flash_entry_register_o;
    logic        req_ready_o, req_refused_o, entry_wr_o, erase_cmd_o, prog_cmd_o, reinit_o;
    logic        done_o, timeout_err_o, slow_o, rewrite_needed_o, user_boot_o;
    fts_req_type req_i = '0;
    fts_map_type host_map_o;
    int          errors = 0, n_checks = 0, dly = 1;
    fts_row_type rows [7] = '{
        '{OP_READ_MODE, 32'h00f00000, 5, 0, 0}, '{OP_ERASE, 32'h00f00000, 10, 0, 0},
        '{OP_ERASE, 32'h00f04000, 150, 0, 1}, '{OP_PROGRAM, 32'h00f00100, 10, 0, 0},
        '{OP_PROGRAM, 32'h00f00200, 40, 0, 1}, '{OP_PROGRAM, 32'h00f00300, 100, 1, 0},
        '{OP_ERASE, 32'h00f08000, 300, 1, 0}};

    fts_supervisor #(.ERASE_TMO(200), .PROG_TMO(60), .ERASE_MAX(100), .PROG_MAX(30)) dut_u (.*);
    fts_flash_model flash_u (.mclk_i(mclk_i), .srst_i(srst_i),
        .start_i(entry_wr_o | erase_cmd_o | prog_cmd_o), .reinit_i(reinit_o),
        .busy_cyc_i(dly), .ready_o(flash_ready_flag_i));

    always #25 mclk_i = ~mclk_i;

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_word

    task automatic end_of_test;
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    // bounded wait, so a lost ready cannot hang the bench
    task automatic run_op(input fts_op_type op, input logic [31:0] addr, input int d);
        int i;
        dly = d;
        @(negedge mclk_i);
        req_i = '{op: op, addr: addr};
        req_valid_i = 1'b1;
        @(negedge mclk_i);
        req_valid_i = 1'b0;
        fin = 1'b0;
        for (i = 0; i < 400 && !fin; i++) begin
            @(negedge mclk_i);
            fin = (done_o === 1'b1) || (reinit_o === 1'b1);
        end
    endtask : run_op

    task automatic host(input logic rd, input logic pe, input logic [31:0] a);
        host_rd_i = rd;
        host_pe_i = pe;
        host_addr_i = a;
        @(negedge mclk_i);
    endtask : host

    initial begin
        #1000000;
        errors++;
        end_of_test();
    end

    initial begin
        repeat (5) @(negedge mclk_i);
        srst_i = 1'b0;
        chk_bit(req_ready_o, 1'b1);
        chk_word({16'h0, flash_entry_register_o}, {16'h0, ENTRY_RESET_VAL});
        repeat (4) @(negedge mclk_i);
        chk_bit(user_boot_o, 1'b1);
        chk_word(reset_vector_o, UBOOT_RESET_VEC);
        foreach (rows[k]) begin
            run_op(rows[k].op, rows[k].addr, rows[k].dly);
            chk_bit(fin, 1'b1);
            chk_bit(timeout_err_o, rows[k].tmo);
            chk_bit(slow_o, rows[k].slow);
            chk_bit(rewrite_needed_o, 1'b0);
            if (rows[k].op != OP_READ_MODE) chk_word(cmd_addr_o, rows[k].addr);
        end
        chk_word({16'h0, flash_entry_register_o}, 32'h0000aa00);
        // protected: start refused and host read not granted
        id_protect_i = 1'b1;
        host(1'b1, 1'b0, 32'hfffffffc);
        req_i = '{op: OP_ERASE, addr: 32'h00f00000};
        req_valid_i = 1'b1;
        @(negedge mclk_i);
        req_valid_i = 1'b0;
        chk_bit(req_refused_o, 1'b1);
        chk_bit(erase_cmd_o, 1'b0);
        chk_bit(host_map_o.granted, 1'b0);
        id_protect_i = 1'b0;
        host(1'b1, 1'b0, 32'hffffffd4);
        chk_bit(host_map_o.fixed_vec, 1'b1);
        chk_bit(host_map_o.granted, 1'b1);
        chk_word(host_map_o.flash_addr, 32'h00ffffd4);
        host(1'b1, 1'b0, 32'hffffffa4);
        chk_bit(host_map_o.id_code, 1'b1);
        host(1'b0, 1'b1, 32'h00fff010);
        chk_bit(host_map_o.lowest_block, 1'b1);
        chk_bit(host_map_o.fixed_vec, 1'b0);
        host(1'b0, 1'b0, 32'h0);
        run_op(OP_ERASE, LOW_BLK_PE_BASE, 8);
        chk_bit(fin, 1'b1);
        @(negedge mclk_i);
        chk_bit(rewrite_needed_o, 1'b1);
        rewrite_ack_i = 1'b1;
        @(negedge mclk_i);
        rewrite_ack_i = 1'b0;
        @(negedge mclk_i);
        chk_bit(rewrite_needed_o, 1'b0);
        // reset in mid-erase; pins now pick the ordinary boot
        dly = 50;
        req_i = '{op: OP_ERASE, addr: 32'h00f0c000};
        req_valid_i = 1'b1;
        @(negedge mclk_i);
        req_valid_i = 1'b0;
        mode_select_pin_high_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk_bit(req_ready_o, 1'b0);
        srst_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        srst_i = 1'b0;
        chk_bit(req_ready_o, 1'b1);
        chk_word({16'h0, flash_entry_register_o}, {16'h0, ENTRY_RESET_VAL});
        repeat (4) @(negedge mclk_i);
        chk_bit(user_boot_o, 1'b0);
        chk_word(reset_vector_o, NORM_RESET_VEC);
        run_op(OP_READ_MODE, 32'h0, 3);
        chk_bit(fin, 1'b1);
        chk_bit(timeout_err_o, 1'b0);
        end_of_test();
    end
endmodule : tb_top
